/* File: design/sdl_regs.v */
// APB register bank controlling eight SerDes quads: lane target, sleep, fine de-emphasis.
// Assumes one core clock; port status inputs come from logic on the same clock.
//
// Design decisions made here: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "sdl_defines.vh"

// Notes on behaviour
// - Lane target codes 0..3 name one lane, 0x10 all lanes, rest reserved.
// - Single-lane target: a lane control write updates only that lane.
// - All-lanes target: a lane control write updates every lane together.
// - Lane control reads return the last value written under a valid target, whatever the target.
// - Lane target sits in control bits 4:0, read-write, resets to all lanes.
// - Sleep bit 5, reset zero, puts lanes in P2 and clock multiplier off.
// - Setting sleep sends each associated port's link training machine to Detect.
// - Clearing sleep powers up, initialises, and starts link training.
// - Sleep has no effect on a SerDes already powered down, e.g. disabled port.
// - Gen 1 fine de-emphasis, bits 1:0, reset 0x2, full swing 2.5 GT/s only.
// - Gen 2 fine de-emphasis bits 3:2, reset 0x3, used at -3.5dB level.
// - Gen 2 fine de-emphasis bits 5:4, reset 0x2, used at -6.0dB level.
// - All fine de-emphasis settings are ignored in low-swing mode.
// - Stored lane values survive software resets for every lane, targeted or not.
module sdl_regs #(
   parameter NS = `SDL_NUM_SERDES,
   parameter NL = `SDL_NUM_LANES
) (
   input wire clk,
   input wire rst,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [`SDL_ADDR_W-1:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire [NS-1:0] port_disabled,
   input wire [NS-1:0] gen2_rate,
   input wire [NS-1:0] deemph_level_choice,
   input wire [NS-1:0] low_swing,
   output reg [NS-1:0] lanes_in_p2,
   output reg [NS-1:0] clock_multiplier_unit_off,
   output reg [NS-1:0] ltssm_to_detect,
   output reg [NS-1:0] ltssm_start_training,
   output reg [NS*NL*`SDL_FDE_W-1:0] fine_deemph_out
);

   // Offset within a SerDes window matches a register
   function hit_off;
      input [`SDL_ADDR_W-1:0] addr;
      input [`SDL_SERDES_SHIFT-1:0] off;
      begin
         hit_off = (addr[`SDL_SERDES_SHIFT-1:0] == off);
      end
   endfunction

   // Lane target code is one the hardware defines
   function sel_valid;
      input [`SDL_SEL_W-1:0] sel;
      begin
         sel_valid = (sel <= `SDL_SEL_MAX_LANE) || (sel == `SDL_SEL_ALL);
      end
   endfunction

   reg [NS*`SDL_SEL_W-1:0] lane_target_select_reg;
   reg [NS-1:0] serdes_sleep_reg;
   wire [NS*`SDL_TXL0_W-1:0] shadow;
   wire [NS*NL*`SDL_TXL0_W-1:0] lane_vals;
   wire [NS*NL*`SDL_FDE_W-1:0] fine_deemph_next;
   wire [2:0] idx;
   wire setup;
   wire access;
   wire wr;
   wire hit_ctl;
   wire hit_txl0;
   wire [NS-1:0] txl0_wr;
   reg [31:0] prdata_next;
   reg pslverr_next;
   integer k;

   assign idx = paddr[`SDL_ADDR_W-1:`SDL_SERDES_SHIFT];
   assign setup = psel & ~penable;
   assign access = psel & penable & pready;
   assign wr = access & pwrite;
   assign hit_ctl = hit_off(paddr, `SDL_CTL_OFF);
   assign hit_txl0 = hit_off(paddr, `SDL_TXL0_OFF);

   // One register set per SerDes
   genvar g;
   generate
      for (g = 0; g < NS; g = g + 1) begin : gen_serdes
         // Reserved target codes drop the write rather than corrupt lanes
         assign txl0_wr[g] = wr & hit_txl0 & (idx == g) &
            sel_valid(lane_target_select_reg[g*`SDL_SEL_W +: `SDL_SEL_W]);

         sdl_lane_store #(
            .LANES(NL)
         ) u_store (
            .clk(clk),
            .rst(rst),
            .wr_en(txl0_wr[g]),
            .wdata(pwdata[`SDL_TXL0_W-1:0]),
            .lane_target_select(lane_target_select_reg[g*`SDL_SEL_W +: `SDL_SEL_W]),
            .shadow_reg(shadow[g*`SDL_TXL0_W +: `SDL_TXL0_W]),
            .lane_reg(lane_vals[g*NL*`SDL_TXL0_W +: NL*`SDL_TXL0_W])
         );

         sdl_deemph_pick #(
            .LANES(NL)
         ) u_pick (
            .lane_vals(lane_vals[g*NL*`SDL_TXL0_W +: NL*`SDL_TXL0_W]),
            .gen2_rate(gen2_rate[g]),
            .deemph_level_choice(deemph_level_choice[g]),
            .low_swing(low_swing[g]),
            .fine_deemph(fine_deemph_next[g*NL*`SDL_FDE_W +: NL*`SDL_FDE_W])
         );
      end
   endgenerate

   // Zero-wait answer: pready rises in the access cycle after every setup
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         pready <= 1'b0;
      end else begin
         pready <= setup;
      end
   end

   // Read data and error are prepared during setup so they stand with pready
   always @* begin
      prdata_next = 32'h0000_0000;
      pslverr_next = 1'b0;
      if (hit_ctl) begin
         prdata_next[`SDL_SEL_LSB +: `SDL_SEL_W] = lane_target_select_reg[idx*`SDL_SEL_W +: `SDL_SEL_W];
         prdata_next[`SDL_SLEEP_BIT] = serdes_sleep_reg[idx];
      end else if (hit_txl0) begin
         prdata_next[`SDL_TXL0_W-1:0] = shadow[idx*`SDL_TXL0_W +: `SDL_TXL0_W];
      end else begin
         pslverr_next = 1'b1;
      end
      if (pwrite) begin
         prdata_next = 32'h0000_0000;
      end
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (setup) begin
         prdata <= prdata_next;
         pslverr <= pslverr_next;
      end else begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
   end

   // Control registers; only the hard reset clears them
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         lane_target_select_reg <= {NS{`SDL_SEL_ALL}};
         serdes_sleep_reg <= {NS{1'b0}};
      end else if (wr & hit_ctl) begin
         lane_target_select_reg[idx*`SDL_SEL_W +: `SDL_SEL_W] <= pwdata[`SDL_SEL_LSB +: `SDL_SEL_W];
         serdes_sleep_reg[idx] <= pwdata[`SDL_SLEEP_BIT];
      end
   end

   // Power state and link training events, suppressed for a SerDes already down
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         lanes_in_p2 <= {NS{1'b0}};
         clock_multiplier_unit_off <= {NS{1'b0}};
         ltssm_to_detect <= {NS{1'b0}};
         ltssm_start_training <= {NS{1'b0}};
      end else begin
         for (k = 0; k < NS; k = k + 1) begin
            lanes_in_p2[k] <= serdes_sleep_reg[k] | port_disabled[k];
            clock_multiplier_unit_off[k] <= serdes_sleep_reg[k] | port_disabled[k];
            ltssm_to_detect[k] <= wr & hit_ctl & (idx == k) & pwdata[`SDL_SLEEP_BIT] &
               ~serdes_sleep_reg[k] & ~port_disabled[k];
            ltssm_start_training[k] <= wr & hit_ctl & (idx == k) & ~pwdata[`SDL_SLEEP_BIT] &
               serdes_sleep_reg[k] & ~port_disabled[k];
         end
      end
   end

   // Registered lane de-emphasis so every output leaves a flip-flop
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         fine_deemph_out <= {NS*NL*`SDL_FDE_W{1'b0}};
      end else begin
         fine_deemph_out <= fine_deemph_next;
      end
   end

endmodule

/* File: design/sdl_defines.vh */
// Constants for the SerDes lane control register bank: offsets, fields, resets.
// Included by every design file of the bank; holds definitions only.
`ifndef SDL_DEFINES_VH
`define SDL_DEFINES_VH

// Address map: SerDes x occupies a 32-byte window at x * 0x20
`define SDL_ADDR_W 8
`define SDL_SERDES_SHIFT 5
`define SDL_CTL_OFF 5'h00
`define SDL_TXL0_OFF 5'h04

// Control register fields
`define SDL_SEL_LSB 0
`define SDL_SEL_W 5
`define SDL_SLEEP_BIT 5
`define SDL_CTL_W 6
`define SDL_SEL_ALL 5'h10
`define SDL_SEL_MAX_LANE 5'h03
`define SDL_CTL_RESET 6'h10

// Transmitter lane control 0 fields
`define SDL_TXL0_W 6
`define SDL_G1_LSB 0
`define SDL_G2_35_LSB 2
`define SDL_G2_60_LSB 4
`define SDL_FDE_W 2
`define SDL_TXL0_RESET 6'h2E

// Structure
`define SDL_NUM_SERDES 8
`define SDL_NUM_LANES 4

`endif

/* File: design/sdl_lane_store.v */
// Per-lane transmitter storage for one SerDes, with lane-target write steering.
// Assumes writes arrive as one-cycle strobes from the register bank on clk.
`timescale 1ns/1ps
`include "sdl_defines.vh"

module sdl_lane_store #(
   parameter LANES = `SDL_NUM_LANES
) (
   input wire clk,
   input wire rst,
   input wire wr_en,
   input wire [`SDL_TXL0_W-1:0] wdata,
   input wire [`SDL_SEL_W-1:0] lane_target_select,
   output reg [`SDL_TXL0_W-1:0] shadow_reg,
   output reg [LANES*`SDL_TXL0_W-1:0] lane_reg
);

   integer i;

   // Shadow keeps the last written value for reads
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         shadow_reg <= `SDL_TXL0_RESET;
      end else if (wr_en) begin
         shadow_reg <= wdata;
      end
   end

   // Only hard reset clears lanes, so untargeted lanes keep their settings
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         lane_reg <= {LANES{`SDL_TXL0_RESET}};
      end else if (wr_en) begin
         for (i = 0; i < LANES; i = i + 1) begin
            if (lane_target_select == `SDL_SEL_ALL) begin
               lane_reg[i*`SDL_TXL0_W +: `SDL_TXL0_W] <= wdata;
            end else if (lane_target_select == i[`SDL_SEL_W-1:0]) begin
               lane_reg[i*`SDL_TXL0_W +: `SDL_TXL0_W] <= wdata;
            end
         end
      end
   end

endmodule

/* File: design/sdl_deemph_pick.v */
// Chooses the active fine de-emphasis value for each lane of one SerDes.
// Assumes rate, level choice and swing mode come from port logic on clk.
`timescale 1ns/1ps
`include "sdl_defines.vh"

module sdl_deemph_pick #(
   parameter LANES = `SDL_NUM_LANES
) (
   input wire [LANES*`SDL_TXL0_W-1:0] lane_vals,
   input wire gen2_rate,
   input wire deemph_level_choice,
   input wire low_swing,
   output reg [LANES*`SDL_FDE_W-1:0] fine_deemph
);

   integer i;

   // Low swing turns de-emphasis off, so every setting is ignored there
   always @* begin
      fine_deemph = {LANES*`SDL_FDE_W{1'b0}};
      for (i = 0; i < LANES; i = i + 1) begin
         if (low_swing) begin
            fine_deemph[i*`SDL_FDE_W +: `SDL_FDE_W] = 2'h0;
         end else if (!gen2_rate) begin
            fine_deemph[i*`SDL_FDE_W +: `SDL_FDE_W] =
               lane_vals[i*`SDL_TXL0_W+`SDL_G1_LSB +: `SDL_FDE_W];
         end else if (deemph_level_choice) begin
            fine_deemph[i*`SDL_FDE_W +: `SDL_FDE_W] =
               lane_vals[i*`SDL_TXL0_W+`SDL_G2_60_LSB +: `SDL_FDE_W];
         end else begin
            fine_deemph[i*`SDL_FDE_W +: `SDL_FDE_W] =
               lane_vals[i*`SDL_TXL0_W+`SDL_G2_35_LSB +: `SDL_FDE_W];
         end
      end
   end

endmodule

/* File: verif/sdl_regs_assertions.sv */
// Checker for the SerDes lane control bank: APB timing, sleep outputs, pulses.
// Sees only the top ports; mirrors sleep bits from APB writes.
`timescale 1ns/1ps
module sdl_regs_chk #(parameter NS = 8, parameter NL = 4) (
   input wire clk,
   input wire rst,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire [NS-1:0] port_disabled,
   input wire [NS-1:0] gen2_rate,
   input wire [NS-1:0] deemph_level_choice,
   input wire [NS-1:0] low_swing,
   input wire [NS-1:0] lanes_in_p2,
   input wire [NS-1:0] clock_multiplier_unit_off,
   input wire [NS-1:0] ltssm_to_detect,
   input wire [NS-1:0] ltssm_start_training,
   input wire [NS*NL*2-1:0] fine_deemph_out
);
   reg [NS-1:0] slp_reg;
   wire [2:0] sx = paddr[7:5];
   wire wr_ctl = psel && penable && pready && pwrite && paddr[4:0] == 5'h00;
   // Mirror of sleep bits, so pulses can be tied to the old state
   always @(posedge clk or posedge rst) begin
      if (rst) slp_reg <= '0;
      else if (wr_ctl) slp_reg[sx] <= pwdata[5];
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_setup; psel && !penable; endsequence
   sequence s_acc; psel && penable && pready; endsequence
   AST_READY: assert property (s_setup |=> pready) else $error("pready not one cycle after setup");
   AST_ONE: assert property (pready |=> !pready) else $error("pready longer than one cycle");
   AST_ERR: assert property (s_acc |-> pslverr == !(paddr[4:0] == 5'h00 || paddr[4:0] == 5'h04))
      else $error("pslverr wrong for offset");
   AST_RD0: assert property (!pready |-> prdata == 32'h0) else $error("prdata outside access");
   AST_P2: assert property (1 |=> lanes_in_p2 == $past(slp_reg | port_disabled)) else $error("p2 state wrong");
   AST_CMU: assert property (clock_multiplier_unit_off == lanes_in_p2) else $error("multiplier off differs");
   AST_DET: assert property (wr_ctl && pwdata[5] && !slp_reg[sx] && !port_disabled[sx]
      |=> ltssm_to_detect == (1 << $past(sx))) else $error("no detect pulse");
   AST_TRN: assert property (wr_ctl && !pwdata[5] && slp_reg[sx] && !port_disabled[sx]
      |=> ltssm_start_training == (1 << $past(sx))) else $error("no training pulse");
   AST_NOPUL: assert property (!wr_ctl |=> (ltssm_to_detect | ltssm_start_training) == 0)
      else $error("pulse without write");
   AST_DIS: assert property (1 |=> ((ltssm_to_detect | ltssm_start_training) & $past(port_disabled)) == 0)
      else $error("pulse on disabled port");
   // Low swing must silence every lane of that SerDes
   for (genvar s = 0; s < NS; s++) begin : g_low
      AST_LOW: assert property (low_swing[s] |=> fine_deemph_out[s*NL*2 +: NL*2] == 0)
         else $error("de-emphasis in low swing");
   end
endmodule
bind sdl_regs sdl_regs_chk #(.NS(NS), .NL(NL)) u_chk (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .port_disabled(port_disabled), .gen2_rate(gen2_rate), .deemph_level_choice(deemph_level_choice),
   .low_swing(low_swing), .lanes_in_p2(lanes_in_p2), .clock_multiplier_unit_off(clock_multiplier_unit_off),
   .ltssm_to_detect(ltssm_to_detect), .ltssm_start_training(ltssm_start_training),
   .fine_deemph_out(fine_deemph_out));

/* File: verif/tb_serdes_lane_control_regs.sv */
// Testbench for the SerDes lane control bank: APB tasks and directed checks.
// Drives every top port itself; no far-side model is needed.
`timescale 1ns/1ps
module tb_serdes_lane_control_regs;
   reg clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, err;
   reg [7:0] paddr = 8'h00, pdis = 8'h00, g2 = 8'h00, lvl = 8'h00, lsw = 8'h00;
   reg [31:0] pwdata = 32'h0, rdat;
   wire [31:0] prdata;
   wire pready, pslverr;
   wire [7:0] p2, clock_multiplier_unit, det, trn;
   wire [63:0] fde;
   integer n_fail = 0, cmp_count = 0;
   sdl_regs DUT (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .port_disabled(pdis),
      .gen2_rate(g2), .deemph_level_choice(lvl), .low_swing(lsw), .lanes_in_p2(p2),
      .clock_multiplier_unit_off(clock_multiplier_unit), .ltssm_to_detect(det), .ltssm_start_training(trn), .fine_deemph_out(fde));
   initial begin
      forever #5 clk = ~clk;
   end
   task results;
   begin
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   end
   endtask
   task chk(input [63:0] got, input [63:0] exp);
   begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
         n_fail = n_fail + 1;
         $display("mismatch t=%0t got %h exp %h", $time, got, exp);
      end
   end
   endtask
   // One APB transfer; request held until pready is sampled high
   task acc(input w, input [7:0] a, input [31:0] d);
   integer n;
   begin
      @(posedge clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'h1;
      n = 0;
      do begin
         @(posedge clk);
         n = n + 1;
      end while (pready !== 1'h1 && n < 16);
      if (n >= 16) begin
         n_fail = n_fail + 1;
         results();
      end
      rdat = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   end
   endtask
   task rd(input [7:0] a, input [31:0] e);
   begin
      acc(1'h0, a, 32'h0);
      chk(rdat, e);
   end
   endtask
   task tick;
   begin
      repeat (2) @(posedge clk);
   end
   endtask
   // Directed sequence over SerDes 1 and 3; SerDes 0 must stay untouched
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'h0;
      rd(8'h00, 32'h10);
      rd(8'h24, 32'h2E);
      chk(fde, {32{2'h2}});
      acc(1'h0, 8'h08, 32'h0);
      chk({rdat, err}, {32'h0, 1'h1});
      acc(1'h1, 8'h20, 32'h01);
      acc(1'h1, 8'h24, 32'h05);
      rd(8'h24, 32'h05);
      tick();
      chk(fde[15:8], 8'hA6);
      acc(1'h1, 8'h20, 32'h10);
      acc(1'h1, 8'h24, 32'h1B);
      tick();
      chk(fde[15:8], 8'hFF);
      g2 <= 8'h02;
      tick();
      chk(fde[15:8], 8'hAA);
      lvl <= 8'h02;
      tick();
      chk(fde[15:8], 8'h55);
      lsw <= 8'h02;
      tick();
      chk(fde[15:8], 8'h00);
      acc(1'h1, 8'h20, 32'hFFFFFFF5);
      @(posedge clk);
      chk(det, 8'h02);
      rd(8'h24, 32'h1B);
      rd(8'h20, 32'h35);
      // Legal target restored before any lane write; sleep stays set, so no pulse
      acc(1'h1, 8'h20, 32'h21);
      @(posedge clk);
      chk({det, trn}, 16'h0000);
      acc(1'h1, 8'h24, 32'h00);
      rd(8'h24, 32'h00);
      pdis <= 8'h08;
      tick();
      chk({clock_multiplier_unit, p2}, 16'h0A0A);
      acc(1'h1, 8'h60, 32'h20);
      @(posedge clk);
      chk({det, trn}, 16'h0000);
      acc(1'h1, 8'h20, 32'h10);
      @(posedge clk);
      chk(trn, 8'h02);
      tick();
      chk({clock_multiplier_unit, p2}, 16'h0808);
      chk(fde[7:0], 8'hAA);
      results();
   end
endmodule
